// >>> hw/timer_pkg.sv
// Shared constants, register map and types for the timer X, Z and C block.
`default_nettype none
package timer_pkg;

  // Register port widths.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // Byte addresses of the registers.
  localparam logic [7:0] A_X_IRQ_CTL = 8'h56;
  localparam logic [7:0] A_Z_IRQ_CTL = 8'h57;
  localparam logic [7:0] A_IRQ_STATUS = 8'h58;
  localparam logic [7:0] A_IRQ_ENABLE = 8'h59;
  localparam logic [7:0] A_IRQ_CLEAR = 8'h5a;
  localparam logic [7:0] A_Z_MODE = 8'h80;
  localparam logic [7:0] A_Z_PRESC = 8'h81;
  localparam logic [7:0] A_Z_SECONDARY = 8'h82;
  localparam logic [7:0] A_Z_PRIMARY = 8'h83;
  localparam logic [7:0] A_Z_ONE_SHOT = 8'h84;
  localparam logic [7:0] A_Z_OUT_SETUP = 8'h85;
  localparam logic [7:0] A_Z_SRC_SEL = 8'h86;
  localparam logic [7:0] A_X_MODE = 8'h88;
  localparam logic [7:0] A_X_PRESC = 8'h89;
  localparam logic [7:0] A_X_COUNT = 8'h8a;
  localparam logic [7:0] A_X_SRC_SEL = 8'h8b;
  localparam logic [7:0] A_C_COUNT_LO = 8'h90;
  localparam logic [7:0] A_C_COUNT_HI = 8'h91;
  localparam logic [7:0] A_C_CC0_LO = 8'h92;
  localparam logic [7:0] A_C_CC0_HI = 8'h93;
  localparam logic [7:0] A_C_CC1_LO = 8'h94;
  localparam logic [7:0] A_C_CC1_HI = 8'h95;
  localparam logic [7:0] A_C_CONTROL = 8'h96;

  // Field widths and bit positions.
  localparam int X_MODE_W = 3;
  localparam int Z_MODE_W = 2;
  localparam int SRC_W = 2;
  localparam int IRQ_LVL_W = 3;
  localparam int X_RUN_BIT = 3;
  localparam int X_EDGE_BIT = 4;
  localparam int X_UNF_BIT = 5;
  localparam int Z_RUN_BIT = 7;
  localparam int Z_ONE_SHOT_BIT = 0;
  localparam int IRQ_REQ_BIT = 3;
  localparam int C_RUN_BIT = 2;
  localparam int C_CTL_W = 3;
  localparam int NUM_EVENTS = 4;
  localparam int ST_X = 0;
  localparam int ST_Z = 1;
  localparam int ST_C_CAP = 2;
  localparam int ST_C_CMP = 3;

  // Mode and count source encodings.
  localparam logic [1:0] X_MODE_PULSE_PERIOD = 2'h3;
  localparam logic [1:0] Z_MODE_ONE_SHOT = 2'h2;
  localparam logic [1:0] Z_MODE_WAIT_ONE_SHOT = 2'h3;
  localparam logic [1:0] SRC_DIV8 = 2'h1;
  localparam logic [1:0] SRC_DIV32 = 2'h2;
  localparam logic [1:0] SRC_PIN = 2'h3;
  localparam logic [4:0] DIV8_LAST = 5'h07;
  localparam logic [4:0] DIV32_LAST = 5'h1f;

  // Reset values.
  localparam logic [7:0] PRESC_RESET = 8'hff;
  localparam logic [7:0] COUNT_RESET = 8'hff;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [15:0] WORD_RESET = 16'h0000;

  // Start and stop state of one timer, one-hot.
  typedef enum logic [3:0] {
    RUN_STOPPED = 4'h1,
    RUN_STARTING = 4'h2,
    RUN_COUNTING = 4'h4,
    RUN_STOPPING = 4'h8
  } run_state_t;

endpackage
`default_nettype wire

// >>> hw/count_unit_if.sv
// Interface between the timer control logic and one prescaler/counter pair.
`timescale 1ns/1ps
`default_nettype none
interface count_unit_if;
  logic tick;
  logic load_pre;
  logic load_cnt;
  logic [7:0] pre_load_data;
  logic [7:0] cnt_load_data;
  logic [7:0] pre_rel;
  logic [7:0] cnt_rel;
  logic [7:0] pre_val;
  logic [7:0] cnt_val;
  logic pre_unf;
  logic cnt_unf;
  modport ctrl (output tick, load_pre, load_cnt, pre_load_data, cnt_load_data, pre_rel, cnt_rel,
                input pre_val, cnt_val, pre_unf, cnt_unf);
  modport unit (input tick, load_pre, load_cnt, pre_load_data, cnt_load_data, pre_rel, cnt_rel,
                output pre_val, cnt_val, pre_unf, cnt_unf);
endinterface
`default_nettype wire

// >>> hw/src_divider.sv
// Count source generator: clock division or a synchronised pin edge.
`timescale 1ns/1ps
`default_nettype none
module src_divider
  import timer_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic [SRC_W-1:0] sel_in,
  input wire logic pin_in,
  output logic tick_out,
  output logic pin_edge_out
);

  typedef struct packed {
    logic [4:0] div;
    logic [2:0] sync;
    logic stable;
  } div_state_t;

  div_state_t r_reg;
  div_state_t r_next;
  logic agree;
  logic div_done;

  // The first sync stage feeds only the second; the filter looks at stages two and three.
  assign agree = (r_reg.sync[1] == r_reg.sync[2]);
  assign pin_edge_out = agree & r_reg.sync[2] & ~r_reg.stable;
  assign div_done = (r_reg.div == 5'h00);
  assign tick_out = (sel_in == SRC_PIN) ? pin_edge_out : div_done;

  // Divider reloads from the selected ratio; pin level is filtered.
  always_comb begin
    r_next = r_reg;
    r_next.sync = {r_reg.sync[1:0], pin_in};
    if (agree) begin
      r_next.stable = r_reg.sync[2];
    end
    if (div_done) begin
      r_next.div = (sel_in == SRC_DIV8) ? DIV8_LAST : (sel_in == SRC_DIV32) ? DIV32_LAST : 5'h00;
    end else begin
      r_next.div = r_reg.div - 5'h01;
    end
  end

  // State register.
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

endmodule
`default_nettype wire

// >>> hw/count_unit.sv
// Eight-bit prescaler feeding an eight-bit down counter, both with reload.
`timescale 1ns/1ps
`default_nettype none
module count_unit
  import timer_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  count_unit_if.unit cu
);

  typedef struct packed {
    logic [7:0] pre;
    logic [7:0] cnt;
  } unit_state_t;

  unit_state_t r_reg;
  unit_state_t r_next;

  // Underflow events for the current count-source tick.
  assign cu.pre_unf = cu.tick & (r_reg.pre == 8'h00);
  assign cu.cnt_unf = cu.pre_unf & (r_reg.cnt == 8'h00);
  assign cu.pre_val = r_reg.pre;
  assign cu.cnt_val = r_reg.cnt;

  // Loads from software win over counting in the same cycle.
  always_comb begin
    r_next = r_reg;
    if (cu.tick) begin
      if (cu.pre_unf) begin
        r_next.pre = cu.pre_rel;
        r_next.cnt = cu.cnt_unf ? cu.cnt_rel : r_reg.cnt - 8'h01;
      end else begin
        r_next.pre = r_reg.pre - 8'h01;
      end
    end
    if (cu.load_pre) begin
      r_next.pre = cu.pre_load_data;
    end
    if (cu.load_cnt) begin
      r_next.cnt = cu.cnt_load_data;
    end
  end

  // State register.
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      r_reg <= '{pre: PRESC_RESET, cnt: COUNT_RESET};
    end else begin
      r_reg <= r_next;
    end
  end

endmodule
`default_nettype wire

// >>> hw/timer_block.sv
// Timers X, Z and C with run control, flags, word reads and interrupt status.
`timescale 1ns/1ps
`default_nettype none
module timer_block
  import timer_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic [ADDR_W-1:0] reg_addr_in,
  input wire logic [DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [DATA_W-1:0] reg_rdata_out,
  input wire logic x_pin_in,
  input wire logic z_pin_in,
  input wire logic c_pin_in,
  output logic irq_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Helper functions.

  // True when a strobe addresses the given register.
  function automatic logic hit(input logic strobe, input logic [7:0] addr, input logic [7:0] target);
    return strobe && (addr == target);
  endfunction

  // Prescaler and counter advance while starting or counting.
  function automatic logic counting(input run_state_t s);
    return (s == RUN_STARTING) || (s == RUN_COUNTING);
  endfunction

  // Value that software sees in a run bit.
  function automatic logic run_visible(input run_state_t s);
    return (s == RUN_COUNTING) || (s == RUN_STOPPING);
  endfunction

  // The run bit follows a start or stop on the next count-source tick; a reversal before that tick acts at once.
  function automatic run_state_t run_next(input run_state_t s, input logic wr, input logic val,
                                          input logic tick);
    run_state_t n;
    n = s;
    case (s)
      RUN_STOPPED: begin
        if (wr && val) begin
          n = RUN_STARTING;
        end
      end
      RUN_STARTING: begin
        if (wr && !val) begin
          n = RUN_STOPPED;
        end else if (tick) begin
          n = RUN_COUNTING;
        end
      end
      RUN_COUNTING: begin
        if (wr && !val) begin
          n = RUN_STOPPING;
        end
      end
      RUN_STOPPING: begin
        if (wr && val) begin
          n = RUN_COUNTING;
        end else if (tick) begin
          n = RUN_STOPPED;
        end
      end
      default: begin
        n = RUN_STOPPED;
      end
    endcase
    return n;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State.

  typedef struct packed {
    logic [X_MODE_W-1:0] x_mode;
    run_state_t x_run;
    logic x_edge;
    logic x_unf;
    logic x_armed;
    logic [7:0] x_pre_rel;
    logic [7:0] x_cnt_rel;
    logic [SRC_W-1:0] x_src;
    logic [Z_MODE_W-1:0] z_mode;
    run_state_t z_run;
    logic z_one_shot;
    logic [7:0] z_pre_rel;
    logic [7:0] z_pri_rel;
    logic [7:0] z_sec;
    logic [7:0] z_out_setup;
    logic [SRC_W-1:0] z_src;
    logic [15:0] c_cnt;
    logic [15:0] c_cc0;
    logic [15:0] c_cc1;
    logic [7:0] c_hold;
    logic [7:0] c_wlo;
    logic [C_CTL_W-1:0] c_ctl;
    logic [NUM_EVENTS-1:0] irq_st;
    logic [NUM_EVENTS-1:0] irq_en;
    logic [IRQ_LVL_W-1:0] x_lvl;
    logic [IRQ_LVL_W-1:0] z_lvl;
    logic [7:0] rdata;
  } top_state_t;

  top_state_t r_reg;
  top_state_t r_next;

  count_unit_if x_cu ();
  count_unit_if z_cu ();

  logic x_tick;
  logic x_pin_edge;
  logic z_tick;
  logic c_tick;
  logic c_pin_edge;
  logic w_x_mode;
  logic w_x_pre;
  logic w_x_cnt;
  logic w_z_mode;
  logic w_z_pre;
  logic w_z_pri;
  logic w_z_os;
  logic x_pulse;
  logic z_os_mode;
  logic z_stop_reload;
  logic z_cnt_en;

  ////////////////////////////////////////////////////////////////////////////
  // Count sources and counter units.

  // Divider for timer X; its pin also supplies the measured edge.
  src_divider u_x_div (
    .core_clk_in(core_clk_in),
    .sys_rst_in(sys_rst_in),
    .sel_in(r_reg.x_src),
    .pin_in(x_pin_in),
    .tick_out(x_tick),
    .pin_edge_out(x_pin_edge)
  );

  // Divider for timer Z.
  src_divider u_z_div (
    .core_clk_in(core_clk_in),
    .sys_rst_in(sys_rst_in),
    .sel_in(r_reg.z_src),
    .pin_in(z_pin_in),
    .tick_out(z_tick),
    .pin_edge_out()
  );

  // Divider for timer C; its pin edge triggers the capture.
  src_divider u_c_div (
    .core_clk_in(core_clk_in),
    .sys_rst_in(sys_rst_in),
    .sel_in(r_reg.c_ctl[SRC_W-1:0]),
    .pin_in(c_pin_in),
    .tick_out(c_tick),
    .pin_edge_out(c_pin_edge)
  );

  count_unit u_x_cnt (
    .core_clk_in(core_clk_in),
    .sys_rst_in(sys_rst_in),
    .cu(x_cu)
  );

  count_unit u_z_cnt (
    .core_clk_in(core_clk_in),
    .sys_rst_in(sys_rst_in),
    .cu(z_cu)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Write decode and unit control.

  // Register write selects.
  assign w_x_mode = hit(reg_wr_in, reg_addr_in, A_X_MODE);
  assign w_x_pre = hit(reg_wr_in, reg_addr_in, A_X_PRESC);
  assign w_x_cnt = hit(reg_wr_in, reg_addr_in, A_X_COUNT);
  assign w_z_mode = hit(reg_wr_in, reg_addr_in, A_Z_MODE);
  assign w_z_pre = hit(reg_wr_in, reg_addr_in, A_Z_PRESC);
  assign w_z_pri = hit(reg_wr_in, reg_addr_in, A_Z_PRIMARY);
  assign w_z_os = hit(reg_wr_in, reg_addr_in, A_Z_ONE_SHOT);
  assign x_pulse = (r_reg.x_mode[1:0] == X_MODE_PULSE_PERIOD);
  assign z_os_mode = (r_reg.z_mode == Z_MODE_ONE_SHOT) || (r_reg.z_mode == Z_MODE_WAIT_ONE_SHOT);

  // Timer X counts only on ticks of a started timer.
  assign x_cu.tick = x_tick & counting(r_reg.x_run);
  assign x_cu.load_pre = w_x_pre;
  assign x_cu.load_cnt = w_x_cnt;
  assign x_cu.pre_load_data = reg_wdata_in;
  assign x_cu.cnt_load_data = reg_wdata_in;
  assign x_cu.pre_rel = r_reg.x_pre_rel;
  assign x_cu.cnt_rel = r_reg.x_cnt_rel;

  // Clearing run or one-shot in a one-shot mode reloads the counter.
  assign z_stop_reload = z_os_mode &&
    ((w_z_mode && !reg_wdata_in[Z_RUN_BIT] && (r_reg.z_run != RUN_STOPPED)) ||
     (w_z_os && !reg_wdata_in[Z_ONE_SHOT_BIT] && r_reg.z_one_shot));
  assign z_cnt_en = counting(r_reg.z_run) && (!z_os_mode || r_reg.z_one_shot);
  assign z_cu.tick = z_tick & z_cnt_en;
  assign z_cu.load_pre = w_z_pre | z_stop_reload;
  assign z_cu.load_cnt = w_z_pri | z_stop_reload;
  assign z_cu.pre_load_data = w_z_pre ? reg_wdata_in : r_reg.z_pre_rel;
  assign z_cu.cnt_load_data = w_z_pri ? reg_wdata_in : r_reg.z_pri_rel;
  assign z_cu.pre_rel = r_reg.z_pre_rel;
  assign z_cu.cnt_rel = r_reg.z_pri_rel;

  // Read data and the interrupt level come straight from registers.
  assign reg_rdata_out = r_reg.rdata;
  assign irq_out = |(r_reg.irq_st & r_reg.irq_en);

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  always_comb begin
    r_next = r_reg;
    r_next.rdata = BYTE_RESET;

    // Run control for both timers, synchronised to their count source.
    r_next.x_run = run_next(r_reg.x_run, w_x_mode, reg_wdata_in[X_RUN_BIT], x_tick);
    r_next.z_run = run_next(r_reg.z_run, w_z_mode, reg_wdata_in[Z_RUN_BIT], z_tick);
    if ((r_reg.x_run == RUN_STARTING) && x_tick) begin
      r_next.x_armed = 1'b1;
    end else if (x_cu.pre_unf) begin
      r_next.x_armed = 1'b0;
    end

    // Timer X mode write; in pulse-period mode flags clear on 0 and keep on 1.
    if (w_x_mode) begin
      r_next.x_mode = reg_wdata_in[X_MODE_W-1:0];
      if (reg_wdata_in[1:0] != r_reg.x_mode[1:0]) begin
        r_next.irq_st[ST_X] = 1'b1;
      end
      if (x_pulse) begin
        r_next.x_edge = r_reg.x_edge & reg_wdata_in[X_EDGE_BIT];
        r_next.x_unf = r_reg.x_unf & reg_wdata_in[X_UNF_BIT];
      end
    end
    if (w_x_pre) begin
      r_next.x_pre_rel = reg_wdata_in;
    end
    if (w_x_cnt) begin
      r_next.x_cnt_rel = reg_wdata_in;
    end
    if (hit(reg_wr_in, reg_addr_in, A_X_SRC_SEL)) begin
      r_next.x_src = reg_wdata_in[SRC_W-1:0];
    end

    // Timer Z registers.
    if (w_z_mode) begin
      r_next.z_mode = reg_wdata_in[Z_MODE_W-1:0];
      if (reg_wdata_in[Z_MODE_W-1:0] != r_reg.z_mode) begin
        r_next.irq_st[ST_Z] = 1'b1;
      end
    end
    if (w_z_os) begin
      r_next.z_one_shot = reg_wdata_in[Z_ONE_SHOT_BIT];
    end
    if (z_stop_reload || (z_os_mode && z_cu.cnt_unf)) begin
      r_next.z_one_shot = 1'b0;
    end
    if (w_z_pre) begin
      r_next.z_pre_rel = reg_wdata_in;
    end
    if (w_z_pri) begin
      r_next.z_pri_rel = reg_wdata_in;
    end
    if (hit(reg_wr_in, reg_addr_in, A_Z_SECONDARY)) begin
      r_next.z_sec = reg_wdata_in;
    end
    if (hit(reg_wr_in, reg_addr_in, A_Z_OUT_SETUP)) begin
      r_next.z_out_setup = reg_wdata_in;
    end
    if (hit(reg_wr_in, reg_addr_in, A_Z_SRC_SEL)) begin
      r_next.z_src = reg_wdata_in[SRC_W-1:0];
    end

    // Timer C: compare holds the low byte until the high byte commits the word.
    if (hit(reg_wr_in, reg_addr_in, A_C_CONTROL)) begin
      r_next.c_ctl = reg_wdata_in[C_CTL_W-1:0];
    end
    if (hit(reg_wr_in, reg_addr_in, A_C_CC1_LO)) begin
      r_next.c_wlo = reg_wdata_in;
    end
    if (hit(reg_wr_in, reg_addr_in, A_C_CC1_HI)) begin
      r_next.c_cc1 = {reg_wdata_in, r_reg.c_wlo};
    end
    if (c_tick && r_reg.c_ctl[C_RUN_BIT]) begin
      r_next.c_cnt = r_reg.c_cnt + 16'h0001;
    end
    if (c_pin_edge) begin
      r_next.c_cc0 = r_reg.c_cnt;
    end

    // Interrupt registers: software clears first, so an event in the same cycle wins.
    if (hit(reg_wr_in, reg_addr_in, A_IRQ_ENABLE)) begin
      r_next.irq_en = reg_wdata_in[NUM_EVENTS-1:0];
    end
    if (hit(reg_wr_in, reg_addr_in, A_IRQ_CLEAR)) begin
      r_next.irq_st = r_next.irq_st & ~reg_wdata_in[NUM_EVENTS-1:0];
    end
    if (hit(reg_wr_in, reg_addr_in, A_X_IRQ_CTL)) begin
      r_next.x_lvl = reg_wdata_in[IRQ_LVL_W-1:0];
      r_next.irq_st[ST_X] = r_next.irq_st[ST_X] & reg_wdata_in[IRQ_REQ_BIT];
    end
    if (hit(reg_wr_in, reg_addr_in, A_Z_IRQ_CTL)) begin
      r_next.z_lvl = reg_wdata_in[IRQ_LVL_W-1:0];
      r_next.irq_st[ST_Z] = r_next.irq_st[ST_Z] & reg_wdata_in[IRQ_REQ_BIT];
    end

    // Hardware events set flags after all clears.
    if (x_pulse && ((x_pin_edge && counting(r_reg.x_run)) || (r_reg.x_armed && x_cu.pre_unf))) begin
      r_next.x_edge = 1'b1;
    end
    if (x_pulse && x_cu.cnt_unf) begin
      r_next.x_unf = 1'b1;
    end
    if (x_cu.cnt_unf) begin
      r_next.irq_st[ST_X] = 1'b1;
    end
    if (z_cu.cnt_unf) begin
      r_next.irq_st[ST_Z] = 1'b1;
    end
    if (c_pin_edge) begin
      r_next.irq_st[ST_C_CAP] = 1'b1;
    end
    if (c_tick && r_reg.c_ctl[C_RUN_BIT] && (r_reg.c_cnt == r_reg.c_cc1)) begin
      r_next.irq_st[ST_C_CMP] = 1'b1;
    end

    // Read mux; data stand only in the cycle after the read strobe.
    if (reg_rd_in) begin
      case (reg_addr_in)
        A_X_MODE: begin
          r_next.rdata = {2'h0, r_reg.x_unf, r_reg.x_edge, run_visible(r_reg.x_run), r_reg.x_mode};
        end
        A_X_PRESC: begin
          r_next.rdata = x_cu.pre_val;
        end
        A_X_COUNT: begin
          r_next.rdata = x_cu.cnt_val;
        end
        A_X_SRC_SEL: begin
          r_next.rdata = {6'h00, r_reg.x_src};
        end
        A_Z_MODE: begin
          r_next.rdata = {run_visible(r_reg.z_run), 5'h00, r_reg.z_mode};
        end
        A_Z_PRESC: begin
          r_next.rdata = z_cu.pre_val;
        end
        A_Z_PRIMARY: begin
          r_next.rdata = z_cu.cnt_val;
        end
        A_Z_SECONDARY: begin
          r_next.rdata = r_reg.z_sec;
        end
        A_Z_ONE_SHOT: begin
          r_next.rdata = {7'h00, r_reg.z_one_shot};
        end
        A_Z_OUT_SETUP: begin
          r_next.rdata = r_reg.z_out_setup;
        end
        A_Z_SRC_SEL: begin
          r_next.rdata = {6'h00, r_reg.z_src};
        end
        A_C_COUNT_LO: begin
          r_next.rdata = r_reg.c_cnt[7:0];
          r_next.c_hold = r_reg.c_cnt[15:8];
        end
        A_C_CC0_LO: begin
          r_next.rdata = r_reg.c_cc0[7:0];
          r_next.c_hold = r_reg.c_cc0[15:8];
        end
        A_C_CC1_LO: begin
          r_next.rdata = r_reg.c_cc1[7:0];
          r_next.c_hold = r_reg.c_cc1[15:8];
        end
        A_C_COUNT_HI, A_C_CC0_HI, A_C_CC1_HI: begin
          r_next.rdata = r_reg.c_hold;
        end
        A_C_CONTROL: begin
          r_next.rdata = {5'h00, r_reg.c_ctl};
        end
        A_X_IRQ_CTL: begin
          r_next.rdata = {4'h0, r_reg.irq_st[ST_X], r_reg.x_lvl};
        end
        A_Z_IRQ_CTL: begin
          r_next.rdata = {4'h0, r_reg.irq_st[ST_Z], r_reg.z_lvl};
        end
        A_IRQ_STATUS: begin
          r_next.rdata = {4'h0, r_reg.irq_st};
        end
        A_IRQ_ENABLE: begin
          r_next.rdata = {4'h0, r_reg.irq_en};
        end
        default: begin
          r_next.rdata = BYTE_RESET;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; both timers come out of reset stopped.

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      r_reg <= '0;
      r_reg.x_run <= RUN_STOPPED;
      r_reg.z_run <= RUN_STOPPED;
      r_reg.x_pre_rel <= PRESC_RESET;
      r_reg.x_cnt_rel <= COUNT_RESET;
      r_reg.z_pre_rel <= PRESC_RESET;
      r_reg.z_pri_rel <= COUNT_RESET;
      r_reg.c_cnt <= WORD_RESET;
    end else begin
      r_reg <= r_next;
    end
  end

endmodule
`default_nettype wire

// >>> sim/timer_block_properties.sv
// Concurrent checks on the timer block register port and interrupt line.
`timescale 1ns/1ps
`default_nettype none
module timer_block_properties
  import timer_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic [ADDR_W-1:0] reg_addr_in,
  input wire logic [DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [DATA_W-1:0] reg_rdata_out,
  input wire logic irq_out
);
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (sys_rst_in);
  // Bus cycles to one address.
  sequence s_wr(logic [7:0] a);
    reg_wr_in && reg_addr_in == a;
  endsequence
  sequence s_rd(logic [7:0] a);
    reg_rd_in && reg_addr_in == a;
  endsequence
  // A cycle in which the given register is not written.
  sequence s_no_wr(logic [7:0] a);
    !(reg_wr_in && reg_addr_in == a);
  endsequence
  // Read data stand only in the cycle after a read.
  property p_rdata_idle;
    !reg_rd_in |=> reg_rdata_out == 8'h00;
  endproperty
  property p_unmapped;
    s_rd(8'h00) |=> reg_rdata_out == 8'h00;
  endproperty
  property p_clear_wo;
    s_rd(A_IRQ_CLEAR) |=> reg_rdata_out == 8'h00;
  endproperty
  property p_status_hi;
    s_rd(A_IRQ_STATUS) |=> reg_rdata_out[7:4] == 4'h0;
  endproperty
  // Interrupt line against the enable register.
  property p_irq_masked;
    s_wr(A_IRQ_ENABLE) ##0 reg_wdata_in[3:0] == 4'h0 ##1 s_no_wr(A_IRQ_ENABLE) |-> !irq_out ##1 !irq_out;
  endproperty
  property p_irq_en_zero;
    s_rd(A_IRQ_ENABLE) ##1 reg_rdata_out[3:0] == 4'h0 |-> !irq_out;
  endproperty
  // Written values read back.
  property p_xirq_rw;
    s_wr(A_X_IRQ_CTL) ##1 s_no_wr(A_X_IRQ_CTL) ##1 s_rd(A_X_IRQ_CTL) |=>
      reg_rdata_out[2:0] == $past(reg_wdata_in[2:0], 3);
  endproperty
  property p_en_rw;
    s_wr(A_IRQ_ENABLE) ##1 s_no_wr(A_IRQ_ENABLE) ##1 s_rd(A_IRQ_ENABLE) |=>
      reg_rdata_out[3:0] == $past(reg_wdata_in[3:0], 3);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_clear_wo: assert property (p_clear_wo) else $error("clear register readable");
  a_status_hi: assert property (p_status_hi) else $error("status upper bits set");
  a_irq_masked: assert property (p_irq_masked) else $error("irq while disabled");
  a_irq_en_zero: assert property (p_irq_en_zero) else $error("irq with zero enable");
  a_xirq_rw: assert property (p_xirq_rw) else $error("x irq level readback");
  a_en_rw: assert property (p_en_rw) else $error("enable readback");
endmodule
bind timer_block timer_block_properties timer_block_properties_inst (.core_clk_in(core_clk_in),
  .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
  .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .irq_out(irq_out));
`default_nettype wire

// >>> sim/tb.sv
// Self-checking bench for the timer block.
`timescale 1ns/1ps
`default_nettype none
module tb
  import timer_pkg::*;
;
  logic core_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic x_pin = 1'b0;
  logic [7:0] rdata;
  logic irq;
  logic [7:0] d, p, c, h;
  logic [1:0] m;
  int n_fail = 0;
  int samples_checked = 0;
  // Free-running 100 MHz clock.
  always #5 core_clk_in = ~core_clk_in;
  timer_block timer_block_inst (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr_s), .reg_rd_in(rd_s), .reg_rdata_out(rdata), .x_pin_in(x_pin),
    .z_pin_in(1'b0), .c_pin_in(1'b0), .irq_out(irq));
  // Bus tasks; a free cycle follows each strobe.
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk_in);
    addr <= a;
    wdata <= v;
    wr_s <= 1'b1;
    @(posedge core_clk_in);
    wr_s <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk_in);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge core_clk_in);
    rd_s <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rc(input string n, input logic [7:0] a, input logic [7:0] e);
    rd(a);
    chk(n, e, d);
  endtask
  // Bounded poll of one bit.
  task automatic poll(input logic [7:0] a, input int b, input logic v);
    rd(a);
    for (int k = 0; k < 40 && d[b] !== v; k++) begin
      rd(a);
    end
    chk("poll", {7'h0, v}, {7'h0, d[b]});
  endtask
  // Pulse-period flags only clear on a written 0.
  function automatic logic [7:0] xexp(input logic [7:0] o, input logic [7:0] w);
    return {2'b00, o[5:4] & w[5:4], w[3:0]};
  endfunction
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Cuts a hang short well past the expected run.
  initial begin
    repeat (20000) @(posedge core_clk_in);
    n_fail++;
    tally_and_finish();
  end
  // Main sequence.
  initial begin
    void'($urandom(56));
    repeat (2) @(posedge core_clk_in);
    sys_rst_in <= 1'b0;
    rc("x_mode", A_X_MODE, 8'h00);
    rc("z_mode", A_Z_MODE, 8'h00);
    rc("x_pre", A_X_PRESC, PRESC_RESET);
    rc("z_cnt", A_Z_PRIMARY, COUNT_RESET);
    wr(8'h00, 8'h5a);
    rc("unmapped", 8'h00, 8'h00);
    $display("done reset");
    p = 8'h02 + 8'($urandom % 250);
    c = 8'($urandom);
    wr(A_X_SRC_SEL, {6'h0, SRC_PIN});
    wr(A_X_PRESC, p);
    wr(A_X_COUNT, c);
    wr(A_X_MODE, 8'h08);
    rc("x_start", A_X_MODE, 8'h00);
    x_pin <= 1'b1;
    poll(A_X_MODE, X_RUN_BIT, 1'b1);
    wr(A_X_MODE, 8'h00);
    x_pin <= 1'b0;
    rc("x_stop", A_X_MODE, 8'h08);
    repeat (4) @(posedge core_clk_in);
    x_pin <= 1'b1;
    poll(A_X_MODE, X_RUN_BIT, 1'b0);
    rc("x_pre_run", A_X_PRESC, p - 8'h01);
    rc("x_cnt_run", A_X_COUNT, c);
    $display("done x run");
    wr(A_X_SRC_SEL, 8'h00);
    wr(A_X_PRESC, 8'h00);
    wr(A_X_COUNT, 8'h00);
    wr(A_X_MODE, 8'h03);
    wr(A_X_MODE, 8'h03);
    wr(A_X_MODE, 8'h0b);
    poll(A_X_MODE, X_RUN_BIT, 1'b1);
    repeat (4) @(posedge core_clk_in);
    wr(A_X_MODE, 8'h33);
    poll(A_X_MODE, X_RUN_BIT, 1'b0);
    chk("x_flags", 8'h33, d);
    wr(A_X_MODE, 8'h23);
    rc("x_edge_clr", A_X_MODE, xexp(8'h33, 8'h23));
    wr(A_X_MODE, 8'h13);
    rc("x_unf_clr", A_X_MODE, xexp(8'h23, 8'h13));
    $display("done x flags");
    wr(A_IRQ_ENABLE, 8'h01);
    rc("irq_en", A_IRQ_ENABLE, 8'h01);
    chk("irq_on", 8'h01, {7'h0, irq});
    rc("x_req", A_X_IRQ_CTL, 8'h08);
    wr(A_X_IRQ_CTL, 8'h05);
    rc("x_irq_ctl", A_X_IRQ_CTL, 8'h05);
    chk("irq_off", 8'h00, {7'h0, irq});
    wr(A_X_MODE, 8'h00);
    rc("status", A_IRQ_STATUS, 8'h01);
    wr(A_IRQ_ENABLE, 8'h00);
    rc("irq_en0", A_IRQ_ENABLE, 8'h00);
    chk("irq_mask", 8'h00, {7'h0, irq});
    wr(A_IRQ_CLEAR, 8'h0f);
    rc("status_clr", A_IRQ_STATUS, 8'h00);
    rc("clear_wo", A_IRQ_CLEAR, 8'h00);
    $display("done irq");
    c = 8'h20 + 8'($urandom % 200);
    wr(A_Z_PRESC, 8'h05);
    wr(A_Z_PRIMARY, c);
    for (int i = 0; i < 2; i++) begin
      m = (i == 0) ? Z_MODE_ONE_SHOT : Z_MODE_WAIT_ONE_SHOT;
      wr(A_Z_SRC_SEL, {6'h0, (i == 0) ? SRC_DIV8 : SRC_DIV32});
      wr(A_Z_MODE, {6'h0, m});
      wr(A_Z_MODE, {1'b1, 5'h0, m});
      poll(A_Z_MODE, Z_RUN_BIT, 1'b1);
      wr(A_Z_ONE_SHOT, 8'h01);
      repeat ((i == 0) ? 60 : 220) @(posedge core_clk_in);
      rd(A_Z_PRIMARY);
      chk("z_counting", 8'h01, {7'h0, d != c});
      if (i == 0) begin
        wr(A_Z_ONE_SHOT, 8'h00);
        rc("z_os_reload", A_Z_PRIMARY, c);
      end
      wr(A_Z_MODE, {6'h0, m});
      poll(A_Z_MODE, Z_RUN_BIT, 1'b0);
      rc("z_reload", A_Z_PRIMARY, c);
      rc("z_pre", A_Z_PRESC, 8'h05);
    end
    $display("done z one-shot");
    wr(A_C_CONTROL, 8'h04);
    rd(A_C_COUNT_LO);
    rd(A_C_COUNT_HI);
    h = d;
    repeat (600) @(posedge core_clk_in);
    rc("c_hi_latch", A_C_COUNT_HI, h);
    rd(A_C_COUNT_LO);
    rd(A_C_COUNT_HI);
    chk("c_hi_new", 8'h01, {7'h0, d != h});
    $display("done c word");
    tally_and_finish();
  end
endmodule
`default_nettype wire
